// ==== design/tpsp_regs.svh ====
// Constants for the shared test pin and diagnostic probe block
// Behaviour
// - Flexible mode: mode-select low claims the scan pins
// - Scan pins stay claimed until logic reset
// - Logic reset returns scan pins to user I/O
// - Logic reset after five scan clocks, mode-select high
// - Dedicated mode: standard state machine, never user I/O
// - Scan clock drives probe and programming logic
// - Serial input shifts test and probe control data
// - Serial output returns shifted data while scanning
// - First probe shows any selected internal node
// - Two probes observe two separate nodes together
// - Probe pins serve as ordinary user I/O
// - One-time probe disable blocks all node routing
`ifndef TPSP_REGS_SVH
`define TPSP_REGS_SVH

// ==========================================================
// Pin indices in the shared scan pin vectors
`define TPSP_PIN_CLK     0
`define TPSP_PIN_DIN     1
`define TPSP_PIN_DOUT    2
`define TPSP_SHARED_N    3

// ==========================================================
// Instruction register
`define TPSP_IR_W        4
`define TPSP_IR_CAPTURE  4'h1
`define TPSP_INS_SAMPLE  4'h1
`define TPSP_INS_PSEL    4'h2
`define TPSP_INS_PLOCK   4'h3
`define TPSP_INS_BYPASS  4'hf

// ==========================================================
// Probe select layout
`define TPSP_SEL_W       4
`define TPSP_PSEL_W      9
`define TPSP_PSEL_RESET  9'h000

// ==========================================================
// Synchroniser width (scan clock, mode select, serial in,
// serial out pin, two probe pins)
`define TPSP_SYNC_N      6

`endif

// ==== design/tpsp_pkg.sv ====
// Types for the shared test pin and diagnostic probe block
`include "tpsp_regs.svh"

package tpsp_pkg;

	// ==========================================================
	// Boundary-scan controller states
	typedef enum logic [3:0] {
		TPSP_TLR        = 4'b0000,
		TPSP_RTI        = 4'b0001,
		TPSP_SEL_DR     = 4'b0010,
		TPSP_CAP_DR     = 4'b0011,
		TPSP_SHIFT_DR   = 4'b0100,
		TPSP_EXIT1_DR   = 4'b0101,
		TPSP_PAUSE_DR   = 4'b0110,
		TPSP_EXIT2_DR   = 4'b0111,
		TPSP_UPD_DR     = 4'b1000,
		TPSP_SEL_IR     = 4'b1001,
		TPSP_CAP_IR     = 4'b1010,
		TPSP_SHIFT_IR   = 4'b1011,
		TPSP_EXIT1_IR   = 4'b1100,
		TPSP_PAUSE_IR   = 4'b1101,
		TPSP_EXIT2_IR   = 4'b1110,
		TPSP_UPD_IR     = 4'b1111
	} tpsp_tap_t;

	// ==========================================================
	// Probe routing selection, loaded over the scan chain
	typedef struct packed {
		logic                   enable;
		logic [`TPSP_SEL_W-1:0] sel_second;
		logic [`TPSP_SEL_W-1:0] sel_first;
	} tpsp_psel_t;

	// ==========================================================
	// User drive of one two-way pin
	typedef struct packed {
		logic out;
		logic oe;
	} tpsp_drv_t;

endpackage

// ==== design/tpsp_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module tpsp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

`default_nettype wire

// ==== design/tpsp_top.sv ====
// Shared scan pin arbitration, scan controller and probe routing
`timescale 1ns/1ps
`default_nettype none
`include "tpsp_regs.svh"

module tpsp_top #(
	parameter int NODE_W = 16
) (
	// Clock, reset and freeze
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	// Configuration levels
	input  wire logic                      dedicated_test_mode,
	input  wire logic                      probe_fuse_blown,
	// Mode-select pin (input only)
	input  wire logic                      mode_sel_pin,
	// Shared scan pins: clock, serial in, serial out
	input  wire logic [`TPSP_SHARED_N-1:0] shared_pin_in,
	output logic      [`TPSP_SHARED_N-1:0] shared_pin_out,
	output logic      [`TPSP_SHARED_N-1:0] shared_pin_oe,
	// User logic side of the shared pins
	input  wire tpsp_pkg::tpsp_drv_t [`TPSP_SHARED_N-1:0] user_shared_drv,
	output logic      [`TPSP_SHARED_N-1:0] user_shared_val,
	// Probe pins
	input  wire logic                      probe_out_first_in,
	output logic                           probe_out_first_out,
	output logic                           probe_out_first_oe,
	input  wire logic                      probe_out_second_in,
	output logic                           probe_out_second_out,
	output logic                           probe_out_second_oe,
	// User logic side of the probe pins
	input  wire tpsp_pkg::tpsp_drv_t       user_first_drv,
	input  wire tpsp_pkg::tpsp_drv_t       user_second_drv,
	output logic      [1:0]                user_probe_val,
	// Internal nodes open to observation
	input  wire logic [NODE_W-1:0]         node_in,
	// Status
	output logic                           scan_active,
	output logic                           scan_tick,
	output logic                           probe_locked,
	output tpsp_pkg::tpsp_tap_t            tap_state,
	output tpsp_pkg::tpsp_psel_t           probe_sel
);

	import tpsp_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [`TPSP_SYNC_N-1:0] sync_q;
	logic                    s_tck;
	logic                    s_tms;
	logic                    s_tdi;
	logic                    tck_prev;
	logic                    tck_rise;
	logic                    tck_fall;

	tpsp_sync #(
		.W (`TPSP_SYNC_N)
	) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.d       ({probe_out_second_in, probe_out_first_in, mode_sel_pin, shared_pin_in}),
		.q       (sync_q)
	);

	// Named views of the synchronised pins
	assign s_tck = sync_q[`TPSP_PIN_CLK];
	assign s_tdi = sync_q[`TPSP_PIN_DIN];
	assign s_tms = sync_q[`TPSP_SHARED_N];

	// Scan clock edge finder on the system clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tck_prev <= 1'b0;
		end else if (ce) begin
			tck_prev <= s_tck;
		end
	end

	// Edges count only while the pins are claimed for scan
	assign tck_rise = s_tck & ~tck_prev & scan_active;
	assign tck_fall = ~s_tck & tck_prev & scan_active;

	// ==========================================================
	// Pin role: scan or user I/O
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_active <= 1'b0;
		end else if (ce) begin
			if (dedicated_test_mode) begin
				scan_active <= 1'b1;
			end else if (!s_tms) begin
				scan_active <= 1'b1;
			end else if (tap_state == TPSP_TLR) begin
				scan_active <= 1'b0;
			end
			// Otherwise hold the claim until logic reset
		end
	end

	// ==========================================================
	// Boundary-scan controller
	tpsp_tap_t next_tap;

	// Standard transitions; five high mode-select clocks reach reset
	always_comb begin
		case (tap_state)
			TPSP_TLR:      next_tap = s_tms ? TPSP_TLR      : TPSP_RTI;
			TPSP_RTI:      next_tap = s_tms ? TPSP_SEL_DR   : TPSP_RTI;
			TPSP_SEL_DR:   next_tap = s_tms ? TPSP_SEL_IR   : TPSP_CAP_DR;
			TPSP_CAP_DR:   next_tap = s_tms ? TPSP_EXIT1_DR : TPSP_SHIFT_DR;
			TPSP_SHIFT_DR: next_tap = s_tms ? TPSP_EXIT1_DR : TPSP_SHIFT_DR;
			TPSP_EXIT1_DR: next_tap = s_tms ? TPSP_UPD_DR   : TPSP_PAUSE_DR;
			TPSP_PAUSE_DR: next_tap = s_tms ? TPSP_EXIT2_DR : TPSP_PAUSE_DR;
			TPSP_EXIT2_DR: next_tap = s_tms ? TPSP_UPD_DR   : TPSP_SHIFT_DR;
			TPSP_UPD_DR:   next_tap = s_tms ? TPSP_SEL_DR   : TPSP_RTI;
			TPSP_SEL_IR:   next_tap = s_tms ? TPSP_TLR      : TPSP_CAP_IR;
			TPSP_CAP_IR:   next_tap = s_tms ? TPSP_EXIT1_IR : TPSP_SHIFT_IR;
			TPSP_SHIFT_IR: next_tap = s_tms ? TPSP_EXIT1_IR : TPSP_SHIFT_IR;
			TPSP_EXIT1_IR: next_tap = s_tms ? TPSP_UPD_IR   : TPSP_PAUSE_IR;
			TPSP_PAUSE_IR: next_tap = s_tms ? TPSP_EXIT2_IR : TPSP_PAUSE_IR;
			TPSP_EXIT2_IR: next_tap = s_tms ? TPSP_UPD_IR   : TPSP_SHIFT_IR;
			TPSP_UPD_IR:   next_tap = s_tms ? TPSP_SEL_DR   : TPSP_RTI;
			default:       next_tap = TPSP_TLR;
		endcase
	end

	// Controller advances on each sampled scan clock rise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tap_state <= TPSP_TLR;
		end else if (ce && tck_rise) begin
			tap_state <= next_tap;
		end
	end

	// Tick for probe and programming logic on each scan clock rise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_tick <= 1'b0;
		end else if (ce) begin
			scan_tick <= tck_rise;
		end
	end

	// ==========================================================
	// Instruction register
	logic [`TPSP_IR_W-1:0] ir_sr;
	logic [`TPSP_IR_W-1:0] ir;

	// Capture, shift from serial in, update; logic reset picks bypass
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ir_sr <= `TPSP_IR_CAPTURE;
			ir    <= `TPSP_INS_BYPASS;
		end else if (ce && tck_rise) begin
			case (tap_state)
				TPSP_TLR:      ir    <= `TPSP_INS_BYPASS;
				TPSP_CAP_IR:   ir_sr <= `TPSP_IR_CAPTURE;
				TPSP_SHIFT_IR: ir_sr <= {s_tdi, ir_sr[`TPSP_IR_W-1:1]};
				TPSP_UPD_IR:   ir    <= ir_sr;
				default:       ir    <= ir;
			endcase
		end
	end

	// ==========================================================
	// Data registers: bypass/lock bit, node sample, probe select
	logic              one_sr;
	logic [NODE_W-1:0] bsr_sr;
	tpsp_psel_t        psel_sr;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			one_sr  <= 1'b0;
			bsr_sr  <= '0;
			psel_sr <= `TPSP_PSEL_RESET;
		end else if (ce && tck_rise) begin
			if (tap_state == TPSP_CAP_DR) begin
				one_sr  <= 1'b0;
				bsr_sr  <= node_in;
				psel_sr <= probe_sel;
			end else if (tap_state == TPSP_SHIFT_DR) begin
				// Serial in feeds test and probe control chains
				case (ir)
					`TPSP_INS_SAMPLE: bsr_sr  <= {s_tdi, bsr_sr[NODE_W-1:1]};
					`TPSP_INS_PSEL:   psel_sr <= {s_tdi, psel_sr[`TPSP_PSEL_W-1:1]};
					default:          one_sr  <= s_tdi;
				endcase
			end
		end
	end

	// ==========================================================
	// Probe selection and one-time disable
	logic lock_now;

	// The blown fuse acts at once; the flop keeps a scan-set lock
	assign lock_now = probe_locked | probe_fuse_blown;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			probe_locked <= 1'b0;
		end else if (ce) begin
			if (probe_fuse_blown) begin
				probe_locked <= 1'b1;
			end else if (tck_rise && tap_state == TPSP_UPD_DR
				&& ir == `TPSP_INS_PLOCK && one_sr) begin
				probe_locked <= 1'b1;
			end
		end
	end

	// Selection loads on update; once locked it is forced off
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			probe_sel <= `TPSP_PSEL_RESET;
		end else if (ce) begin
			if (lock_now) begin
				probe_sel <= `TPSP_PSEL_RESET;
			end else if (tck_rise && tap_state == TPSP_UPD_DR
				&& ir == `TPSP_INS_PSEL) begin
				probe_sel <= psel_sr;
			end
		end
	end

	// ==========================================================
	// Serial output, changing on the scan clock fall
	logic tdo_q;
	logic tdo_en;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tdo_q  <= 1'b0;
			tdo_en <= 1'b0;
		end else if (ce && tck_fall) begin
			tdo_en <= (tap_state == TPSP_SHIFT_IR) || (tap_state == TPSP_SHIFT_DR);
			if (tap_state == TPSP_SHIFT_IR) begin
				tdo_q <= ir_sr[0];
			end else if (tap_state == TPSP_SHIFT_DR) begin
				case (ir)
					`TPSP_INS_SAMPLE: tdo_q <= bsr_sr[0];
					`TPSP_INS_PSEL:   tdo_q <= psel_sr[0];
					default:          tdo_q <= one_sr;
				endcase
			end
		end
	end

	// ==========================================================
	// Shared pin drivers and user-side values
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shared_pin_out  <= '0;
			shared_pin_oe   <= '0;
			user_shared_val <= '0;
		end else if (ce) begin
			if (scan_active) begin
				// Clock and serial in listen; serial out drives while shifting
				shared_pin_out  <= '0;
				shared_pin_oe   <= '0;
				shared_pin_out[`TPSP_PIN_DOUT] <= tdo_q;
				shared_pin_oe[`TPSP_PIN_DOUT]  <= tdo_en;
				user_shared_val <= '0;
			end else begin
				for (int i = 0; i < `TPSP_SHARED_N; i++) begin
					shared_pin_out[i] <= user_shared_drv[i].out;
					shared_pin_oe[i]  <= user_shared_drv[i].oe;
				end
				user_shared_val <= sync_q[`TPSP_SHARED_N-1:0];
			end
		end
	end

	// ==========================================================
	// Probe pin drivers
	logic route_on;

	assign route_on = probe_sel.enable & ~lock_now;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			probe_out_first_out  <= 1'b0;
			probe_out_first_oe   <= 1'b0;
			probe_out_second_out <= 1'b0;
			probe_out_second_oe  <= 1'b0;
			user_probe_val       <= '0;
		end else if (ce) begin
			if (route_on) begin
				// Two independent selections observed at once
				probe_out_first_out  <= node_in[probe_sel.sel_first];
				probe_out_first_oe   <= 1'b1;
				probe_out_second_out <= node_in[probe_sel.sel_second];
				probe_out_second_oe  <= 1'b1;
				user_probe_val       <= '0;
			end else begin
				probe_out_first_out  <= user_first_drv.out;
				probe_out_first_oe   <= user_first_drv.oe;
				probe_out_second_out <= user_second_drv.out;
				probe_out_second_oe  <= user_second_drv.oe;
				user_probe_val       <= sync_q[`TPSP_SYNC_N-1:`TPSP_SYNC_N-2];
			end
		end
	end

endmodule

`default_nettype wire

// ==== test/tpsp_sva.sv ====
// Port assertions for the shared scan pin and probe block
`timescale 1ns/1ps
`default_nettype none
`include "tpsp_regs.svh"

module tpsp_sva
	import tpsp_pkg::*;
#(
	parameter int NODE_W = 16
) (
	// Clock, reset and levels
	input wire logic                 sys_clk,
	input wire logic                 rst,
	input wire logic                 ce,
	input wire logic                 dedicated_test_mode,
	input wire logic                 probe_fuse_blown,
	input wire logic                 mode_sel_pin,
	// Shared pins and user side
	input wire logic [2:0]           shared_pin_out,
	input wire logic [2:0]           shared_pin_oe,
	input wire tpsp_pkg::tpsp_drv_t [`TPSP_SHARED_N-1:0] user_shared_drv,
	// Probes and status
	input wire logic                 probe_out_first_out,
	input wire logic                 probe_out_first_oe,
	input wire logic                 probe_out_second_out,
	input wire logic                 probe_out_second_oe,
	input wire logic [NODE_W-1:0]    node_in,
	input wire logic                 scan_active,
	input wire logic                 scan_tick,
	input wire logic                 probe_locked,
	input wire tpsp_pkg::tpsp_tap_t  tap_state,
	input wire tpsp_pkg::tpsp_psel_t probe_sel
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Mode select held low or high
	sequence ms_low4;
		(ce && !mode_sel_pin)[*4];
	endsequence
	sequence ms_high4;
		(ce && mode_sel_pin)[*4];
	endsequence

	// Scan ticks taken while mode select stays high
	logic [3:0] hi_run;
	logic [2:0] hi_ticks;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst || !mode_sel_pin) begin
			hi_run <= 4'h0;
			hi_ticks <= 3'h0;
		end else begin
			if (hi_run != 4'hf) hi_run <= hi_run + 4'h1;
			if (scan_tick && hi_run >= 4'h6 && hi_ticks != 3'h7) hi_ticks <= hi_ticks + 3'h1;
		end
	end

	// ==========================================================
	// Pin role
	claim_pins_a: assert property (ms_low4 |-> ##[1:2] scan_active)
		else $error("scan pins not claimed");
	hold_scan_a: assert property (scan_active && tap_state != TPSP_TLR |=> scan_active)
		else $error("scan pins left early");
	release_pins_a: assert property (ms_high4 ##0 (scan_active && tap_state == TPSP_TLR
		&& !dedicated_test_mode) |-> ##[1:2] !scan_active)
		else $error("scan pins not released");
	five_ticks_a: assert property (hi_ticks >= 3'h5 |-> tap_state == TPSP_TLR)
		else $error("no logic reset after five ticks");
	dedicated_a: assert property (dedicated_test_mode [*3] |-> scan_active)
		else $error("dedicated mode left scan");
	scan_quiet_a: assert property (scan_active && $past(scan_active)
		|-> shared_pin_oe[1:0] == 2'b00)
		else $error("scan input pins driven");
	user_route_a: assert property (!scan_active && !$past(scan_active) && !$past(rst)
		&& !dedicated_test_mode |-> shared_pin_oe[1] == $past(user_shared_drv[1].oe)
		&& shared_pin_out[1] == $past(user_shared_drv[1].out))
		else $error("user pin not routed");
	tdo_shift_a: assert property (shared_pin_oe[2] && scan_active |-> tap_state inside
		{TPSP_SHIFT_DR, TPSP_EXIT1_DR, TPSP_SHIFT_IR, TPSP_EXIT1_IR})
		else $error("serial out driven off shift");

	// ==========================================================
	// Probe routing
	probe_first_a: assert property (ce && probe_sel.enable && !probe_locked
		&& !probe_fuse_blown
		|=> probe_out_first_oe && probe_out_first_out == $past(node_in[probe_sel.sel_first]))
		else $error("first probe wrong node");
	probe_second_a: assert property (ce && probe_sel.enable && !probe_locked
		&& !probe_fuse_blown
		|=> probe_out_second_oe && probe_out_second_out == $past(node_in[probe_sel.sel_second]))
		else $error("second probe wrong node");
	probe_lock_a: assert property (probe_fuse_blown || probe_locked
		|-> ##[1:2] (probe_locked && !probe_sel.enable))
		else $error("probe lock not held");
endmodule

bind tpsp_top tpsp_sva #(.NODE_W(NODE_W)) u_sva (.sys_clk, .rst, .ce, .dedicated_test_mode,
	.probe_fuse_blown, .mode_sel_pin, .shared_pin_out, .shared_pin_oe, .user_shared_drv,
	.probe_out_first_out, .probe_out_first_oe, .probe_out_second_out, .probe_out_second_oe,
	.node_in, .scan_active, .scan_tick, .probe_locked, .tap_state, .probe_sel);
`default_nettype wire

// ==== test/tpsp_scan_model.sv ====
// Behavioural scan controller on the far side of the scan pins
`timescale 1ns/1ps
`default_nettype none

module tpsp_scan_model (
	// Serial out from the device
	input wire logic tdo,
	// Scan clock, mode select, serial in
	output logic     tck,
	output logic     tms,
	output logic     tdi
);
	// Clock stands low between steps, mode select idles high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One 125 ns scan clock; long low phase lets serial out settle
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		q = tdo;
		tck = 1'b1;
		#45;
		tck = 1'b0;
	endtask

	// Whole IR or DR scan from idle, LSB first, back to idle
	task automatic scan(input logic ir, input logic [15:0] v, input int n,
		output logic [15:0] r);
		logic q;
		r = 16'h0000;
		step(1'b1, 1'b0, q);
		if (ir) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], q);
			r[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule
`default_nettype wire

// ==== test/test_pin_sharing_probe_test.sv ====
// Self-checking bench for the shared scan pin and probe block
`timescale 1ns/1ps
`default_nettype none

module test_pin_sharing_probe_test;
	import tpsp_pkg::*;
	// ==========================================================
	// Design signals and counters
	logic sys_clk = 1'b0, rst = 1'b1, dedicated_test_mode = 1'b0, probe_fuse_blown = 1'b0;
	logic ce = 1'b1;
	logic [2:0]      shared_pin_in, shared_pin_out, shared_pin_oe, user_shared_val;
	tpsp_drv_t [2:0] user_shared_drv = '0;
	tpsp_drv_t       user_first_drv = '0, user_second_drv = '0;
	logic            probe_out_first_out, probe_out_first_oe;
	logic            probe_out_second_out, probe_out_second_oe;
	logic [1:0]      user_probe_val;
	logic [15:0]     node_in = 16'h0000;
	logic            scan_active, scan_tick, probe_locked, tdo_last = 1'b0;
	tpsp_tap_t       tap_state;
	tpsp_psel_t      probe_sel;
	wire logic       tck, tms, tdi;
	int              failures = 0, num_checks = 0, cycles = 0;

	always #5 sys_clk = ~sys_clk;

	// Pin levels: released serial out shows the inverse of its last value
	assign shared_pin_in = {shared_pin_oe[2] ? shared_pin_out[2] : ~tdo_last,
		shared_pin_oe[1] ? shared_pin_out[1] : tdi, shared_pin_oe[0] ? shared_pin_out[0] : tck};
	always @(posedge sys_clk) if (shared_pin_oe[2]) tdo_last <= shared_pin_out[2];

	tpsp_top #(.NODE_W(16)) DUT (.sys_clk, .rst, .ce, .dedicated_test_mode,
		.probe_fuse_blown, .mode_sel_pin(tms), .shared_pin_in, .shared_pin_out, .shared_pin_oe,
		.user_shared_drv, .user_shared_val, .probe_out_first_in(probe_out_first_out),
		.probe_out_first_out, .probe_out_first_oe, .probe_out_second_in(probe_out_second_out),
		.probe_out_second_out, .probe_out_second_oe, .user_first_drv, .user_second_drv,
		.user_probe_val, .node_in, .scan_active, .scan_tick, .probe_locked, .tap_state,
		.probe_sel);
	tpsp_scan_model CTL (.tdo(shared_pin_in[2]), .tck, .tms, .tdi);

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_claim();
		logic q;
		@(posedge sys_clk) user_shared_drv[1] <= 2'b11;
		wait_clk(3);
		chk(16'(shared_pin_oe), 16'h2); // User drive
		CTL.step(1'b0, 1'b0, q);
		chk(16'({scan_active, shared_pin_oe}), 16'h8); // Claimed
		chk(16'(tap_state), 16'(TPSP_RTI)); // Idle
		$display("test claim done");
	endtask

	task automatic t_probe();
		logic [15:0] r;
		CTL.scan(1'b1, 16'h0002, 4, r);
		chk(r, 16'h0001); // IR capture
		CTL.scan(1'b0, 16'h015a, 9, r);
		chk(r, 16'h0000); // Old select
		chk(16'(probe_sel), 16'h015a); // Loaded
		@(posedge sys_clk) node_in <= 16'h0400;
		wait_clk(2);
		chk(16'({probe_out_second_out, probe_out_first_out, probe_out_first_oe}), 16'h3);
		@(posedge sys_clk) node_in <= 16'h0020;
		wait_clk(2);
		chk(16'({probe_out_second_out, probe_out_first_out}), 16'h2); // Both
		CTL.scan(1'b1, 16'h0001, 4, r);
		CTL.scan(1'b0, 16'h5a3c, 16, r);
		chk(r, 16'h0020); // Node sample
		$display("test probe done");
	endtask

	task automatic t_lock();
		logic [15:0] r;
		CTL.scan(1'b1, 16'h0003, 4, r);
		CTL.scan(1'b0, 16'h0001, 1, r);
		CTL.scan(1'b1, 16'h0002, 4, r);
		CTL.scan(1'b0, 16'h015a, 9, r);
		chk(16'({probe_locked, probe_out_second_oe, probe_out_second_out}), 16'h4);
		@(posedge sys_clk) user_first_drv <= 2'b11;
		wait_clk(5);
		chk(16'({probe_out_first_oe, probe_out_first_out, user_probe_val[0]}), 16'h7);
		// Clock enable low freezes the probe pin drive
		@(posedge sys_clk) begin
			ce <= 1'b0;
			user_first_drv <= 2'b00;
		end
		wait_clk(4);
		chk(16'({probe_out_first_oe, probe_out_first_out}), 16'h3); // Frozen
		@(posedge sys_clk) ce <= 1'b1;
		wait_clk(3);
		chk(16'({probe_out_first_oe, probe_out_first_out}), 16'h0); // Resumes
		$display("test lock done");
	endtask

	task automatic t_release();
		logic q;
		CTL.step(1'b1, 1'b0, q);
		CTL.step(1'b0, 1'b0, q);
		CTL.step(1'b0, 1'b0, q);
		for (int i = 0; i < 4; i++) CTL.step(1'b1, 1'b0, q); // High four
		chk(16'(scan_active), 16'h1); // Still held
		CTL.step(1'b1, 1'b0, q);
		chk(16'(tap_state), 16'(TPSP_TLR)); // Fifth tick
		@(posedge sys_clk) user_shared_drv[0] <= 2'b11;
		wait_clk(5);
		chk(16'({scan_active, shared_pin_oe, user_shared_val[1:0]}), 16'hf);
		$display("test release done");
	endtask

	task automatic t_dedicated();
		logic q;
		@(posedge sys_clk) rst <= 1'b1;
		dedicated_test_mode <= 1'b1;
		probe_fuse_blown <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		wait_clk(4);
		chk(16'({scan_active, probe_locked, shared_pin_oe[1:0]}), 16'hc);
		for (int i = 0; i < 5; i++) CTL.step(1'b1, 1'b0, q);
		chk(16'({scan_active, tap_state}), 16'h10); // Kept
		CTL.step(1'b0, 1'b0, q);
		chk(16'(tap_state), 16'(TPSP_RTI)); // Standard walk
		$display("test dedicated done");
	endtask

	// ==========================================================
	// Main sequence and hang guard
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		wait_clk(8);
		t_claim();
		t_probe();
		t_lock();
		t_release();
		t_dedicated();
		stop_test();
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			stop_test();
		end
	end
endmodule
`default_nettype wire
